/* File: apit_pkg.sv */
package apit_pkg;

    // ****************************************
    // Register map: word index, byte address is four times it
    // ****************************************
    localparam logic [11:0] APIT_IDX_TRIM = 12'h2F3;
    localparam logic [11:0] APIT_IDX_RATE_HI = 12'h2F4;
    localparam logic [11:0] APIT_IDX_RATE_LO = 12'h2F5;
    localparam logic [11:0] APIT_IDX_CTRL = 12'h2F2;
    localparam logic [11:0] APIT_ADDR_TRIM = {APIT_IDX_TRIM[9:0], 2'b00};
    localparam logic [11:0] APIT_ADDR_RATE_HI = {APIT_IDX_RATE_HI[9:0], 2'b00};
    localparam logic [11:0] APIT_ADDR_RATE_LO = {APIT_IDX_RATE_LO[9:0], 2'b00};
    localparam logic [11:0] APIT_ADDR_CTRL = {APIT_IDX_CTRL[9:0], 2'b00};
    localparam int APIT_AW = 14;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int APIT_B_SRC = 7;
    localparam int APIT_B_WSEL = 4;
    localparam int APIT_B_OEN = 3;
    localparam int APIT_B_FEN = 2;
    localparam int APIT_B_IEN = 1;
    localparam int APIT_B_FLAG = 0;
    localparam int APIT_TRIM_LSB = 2;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0] APIT_RST_CTRL = 8'h00;
    localparam logic [15:0] APIT_RST_RATE = 16'h0000;
    localparam logic [5:0] APIT_RST_TRIM = 6'h00;
    localparam int APIT_SYS_HZ = 20000000;
    localparam int APIT_SLOW_HZ = 20000;
    // Slow tick period in system cycles at nominal trim
    localparam int APIT_SLOW_CYC = APIT_SYS_HZ / APIT_SLOW_HZ;
    // Trim step in system cycles per trim unit
    localparam int APIT_TRIM_STEP = 8;
    localparam int APIT_GATE_TICKS = 2;

    typedef struct packed {
        logic src_bus;
        logic wave_sel;
        logic out_en;
        logic feat_en;
        logic irq_en;
    } apit_ctrl_t;

endpackage

/* File: apit_slow_osc.sv */
module apit_slow_osc
    import apit_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Trim
    input wire logic [5:0] i_trim,
    // Tick
    output logic o_tick
);

    // ****************************************
    // Trimmed divider
    // ****************************************
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    logic [11:0] limit;
    logic signed [11:0] adj;

    always_comb
    begin
        // Top bit lengthens, lower bits shorten with falling weight
        adj = i_trim[5] ? 12'(32 * APIT_TRIM_STEP) : 12'h000;
        adj = adj - 12'(i_trim[4:0] * APIT_TRIM_STEP);
        // Nominal 20 kHz at zero trim
        limit = 12'(APIT_SLOW_CYC - 1) + 12'(adj);
        next_cnt = (cnt >= limit) ? 12'h000 : cnt + 12'h001;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt <= 12'h000;
        else
            cnt <= next_cnt;
    end

    assign o_tick = (cnt >= limit);

endmodule

/* File: apit_period.sv */
module apit_period
    import apit_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [15:0] i_rate,
    // Events
    output logic o_half,
    output logic o_timeout
);

    // ****************************************
    // Half-period counter
    // ****************************************
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic phase;
    logic next_phase;

    always_comb
    begin
        next_cnt = cnt;
        next_phase = phase;
        o_half = 1'b0;
        o_timeout = 1'b0;
        if (!i_run)
        begin
            next_cnt = 16'h0000;
            next_phase = 1'b0;
        end
        else if (i_tick)
        begin
            if (cnt == i_rate)
            begin
                // Period is 2*(rate+1) ticks, restarts itself
                next_cnt = 16'h0000;
                next_phase = ~phase;
                o_half = ~phase;
                o_timeout = phase;
            end
            else
                next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt <= 16'h0000;
            phase <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            phase <= next_phase;
        end
    end

endmodule

/* File: apit_top.sv */
// What this block does
// - Source bit 0 counts slow RC ticks, 1 counts bus clock.
// - Source bit writable only when enable clear before and in the write.
// - Pulse mode gives a high pulse each period end, half minimum period wide.
// - Square mode toggles pin each period, giving twice the period.
// - Pin shows wave only when output enable and feature enable set.
// - Feature enable starts the timer; clearing stops it.
// - Interrupt request equals flag and interrupt enable.
// - Flag sets at every elapsed period while running.
// - Flag clears only by writing one to it.
// - Trim is signed six-bit field in bits 7 to 2.
// - Trim loaded from flash after reset release.
// - Top trim bit lengthens, lower bits shorten with falling weight.
// - Rate is sixteen bits in high and low byte registers.
// - Rate writes are dropped while feature enabled.
// - Slow period is 2*(rate+1)*2 slow clock periods.
// - Bus period is 2*(rate+1) bus clock periods.
// - Slow start waits two slow ticks, one to two slow cycles, for gate release.
// - Slow clock is nominally 20 kHz.
module apit_top
    import apit_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APIT_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Flash trim load
    input wire logic i_trim_load,
    input wire logic [5:0] i_trim_flash,
    // Outputs
    output logic o_periodic_irq,
    output logic o_periodic_wave_pin
);

    // ****************************************
    // State
    // ****************************************
    apit_ctrl_t ctrl;
    apit_ctrl_t next_ctrl;
    logic flag;
    logic next_flag;
    logic [15:0] rate;
    logic [15:0] next_rate;
    logic [5:0] trim;
    logic [5:0] next_trim;
    logic wave;
    logic next_wave;
    logic pulse;
    logic next_pulse;
    logic [1:0] gate;
    logic [1:0] next_gate;
    logic [31:0] next_prdata;
    logic slow_tick;
    logic slow_half;
    logic half_ev;
    logic timeout;
    logic run;
    logic tick;
    logic wr;
    logic rd;
    logic [7:0] wd;
    logic [11:0] adr;
    logic hit;

    // ****************************************
    // Submodules
    // ****************************************
    apit_slow_osc u_osc
    (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_trim(trim),
        .o_tick(slow_tick)
    );

    apit_period u_per
    (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_run(run),
        .i_tick(tick),
        .i_rate(rate),
        .o_half(half_ev),
        .o_timeout(timeout)
    );

    // ****************************************
    // Bus decode
    // ****************************************
    assign adr = i_paddr[11:0];
    assign wd = i_pwdata[7:0];
    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_penable && !i_pwrite;
    assign hit = (adr == APIT_ADDR_CTRL) || (adr == APIT_ADDR_TRIM)
        || (adr == APIT_ADDR_RATE_HI) || (adr == APIT_ADDR_RATE_LO);
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    // With slow source each count tick is two slow ticks of the divider
    assign tick = ctrl.src_bus ? 1'b1 : (slow_tick && slow_half);
    assign run = ctrl.feat_en && (ctrl.src_bus || gate == 2'(APIT_GATE_TICKS));

    // ****************************************
    // Slow clock halving
    // ****************************************
    logic half_tgl;
    logic next_half_tgl;

    // Count tick is every second slow tick
    always_comb
    begin
        next_half_tgl = half_tgl;
        if (slow_tick)
            next_half_tgl = ~half_tgl;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            half_tgl <= 1'b0;
        end
        else
        begin
            half_tgl <= next_half_tgl;
        end
    end

    assign slow_half = half_tgl;

    // ****************************************
    // Control register
    // ****************************************
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr && adr == APIT_ADDR_CTRL)
        begin
            // Source held while enabled or being enabled
            if (!ctrl.feat_en && !wd[APIT_B_FEN])
                next_ctrl.src_bus = wd[APIT_B_SRC];
            next_ctrl.wave_sel = wd[APIT_B_WSEL];
            next_ctrl.out_en = wd[APIT_B_OEN];
            next_ctrl.feat_en = wd[APIT_B_FEN];
            next_ctrl.irq_en = wd[APIT_B_IEN];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl <= apit_ctrl_t'(APIT_RST_CTRL[4:0]);
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // ****************************************
    // Time-out flag
    // ****************************************
    always_comb
    begin
        next_flag = flag;
        if (wr && adr == APIT_ADDR_CTRL && wd[APIT_B_FLAG])
            next_flag = 1'b0;
        // Set wins over a clear in the same cycle
        if (timeout)
            next_flag = 1'b1;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            flag <= 1'b0;
        end
        else
        begin
            flag <= next_flag;
        end
    end

    // ****************************************
    // Rate registers
    // ****************************************
    always_comb
    begin
        next_rate = rate;
        // Writes dropped while feature enable is set, including the start gate wait
        if (wr && adr == APIT_ADDR_RATE_HI && !ctrl.feat_en)
            next_rate[15:8] = wd;
        if (wr && adr == APIT_ADDR_RATE_LO && !ctrl.feat_en)
            next_rate[7:0] = wd;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rate <= APIT_RST_RATE;
        end
        else
        begin
            rate <= next_rate;
        end
    end

    // ****************************************
    // Trim register
    // ****************************************
    always_comb
    begin
        next_trim = trim;
        if (i_trim_load)
            next_trim = i_trim_flash;
        if (wr && adr == APIT_ADDR_TRIM)
            next_trim = wd[7:APIT_TRIM_LSB];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            trim <= APIT_RST_TRIM;
        end
        else
        begin
            trim <= next_trim;
        end
    end

    // ****************************************
    // Start gate
    // ****************************************
    // Opens after two slow ticks
    always_comb
    begin
        next_gate = gate;
        if (!ctrl.feat_en)
            next_gate = 2'b00;
        else if (slow_tick && gate != 2'(APIT_GATE_TICKS))
            next_gate = gate + 2'b01;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gate <= 2'b00;
        end
        else
        begin
            gate <= next_gate;
        end
    end

    // ****************************************
    // Pin waveforms
    // ****************************************
    always_comb
    begin
        next_wave = wave;
        next_pulse = pulse;
        // Pulse lasts one count tick, half the minimum period
        if (!run)
        begin
            next_wave = 1'b0;
            next_pulse = 1'b0;
        end
        else if (timeout)
        begin
            next_wave = ~wave;
            next_pulse = 1'b1;
        end
        else if (tick)
            next_pulse = 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wave <= 1'b0;
            pulse <= 1'b0;
        end
        else
        begin
            wave <= next_wave;
            pulse <= next_pulse;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Captured in the setup cycle, stands until the next read
    always_comb
    begin
        next_prdata = o_prdata;
        if (rd)
        begin
            next_prdata = 32'h0000_0000;
            unique case (adr)
                APIT_ADDR_CTRL: next_prdata[7:0] = {ctrl.src_bus, 2'b00, ctrl.wave_sel,
                    ctrl.out_en, ctrl.feat_en, ctrl.irq_en, flag};
                APIT_ADDR_TRIM: next_prdata[7:0] = {trim, 2'b00};
                APIT_ADDR_RATE_HI: next_prdata[7:0] = rate[15:8];
                APIT_ADDR_RATE_LO: next_prdata[7:0] = rate[7:0];
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_prdata <= 32'h0000_0000;
        end
        else
        begin
            o_prdata <= next_prdata;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_periodic_irq = flag && ctrl.irq_en;
    assign o_periodic_wave_pin = ctrl.out_en && ctrl.feat_en
        && (ctrl.wave_sel ? wave : pulse);

endmodule

/* File: apit_top_asserts.sv */
module apit_top_asserts
    import apit_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APIT_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Outputs
    input wire logic o_periodic_irq,
    input wire logic o_periodic_wave_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // ****************************************
    // Shadow control: src, wsel, oen, fen, ien
    // ****************************************
    logic [4:0] sh;
    logic [4:0] next_sh;
    logic wr_ctrl;
    logic mapped;
    logic pin_on;
    assign pin_on = sh[2] && sh[1];
    assign wr_ctrl = i_psel && i_penable && i_pwrite && i_paddr[11:0] == APIT_ADDR_CTRL;
    assign mapped = i_paddr[11:0] inside {APIT_ADDR_CTRL, APIT_ADDR_TRIM,
        APIT_ADDR_RATE_HI, APIT_ADDR_RATE_LO};
    always_comb
    begin
        next_sh = sh;
        if (wr_ctrl)
        begin
            next_sh[3:0] = i_pwdata[4:1];
            if (!sh[1] && !i_pwdata[2])
            begin
                next_sh[4] = i_pwdata[7];
            end
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sh <= '0;
        end
        else
        begin
            sh <= next_sh;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    a_ready_always: assert property (o_pready)
        else $error("pready low");
    a_err_unmapped: assert property (i_psel && i_penable && !mapped |-> o_pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (i_psel && i_penable && mapped |-> !o_pslverr)
        else $error("error on mapped access");
    a_rdata_upper: assert property (o_prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_irq_masked: assert property (!sh[0] && !$past(sh[0]) |-> !o_periodic_irq)
        else $error("irq while disabled");
    a_irq_holds: assert property (o_periodic_irq && !wr_ctrl |=> o_periodic_irq)
        else $error("irq dropped without write");
    a_pin_gated: assert property (!pin_on && !$past(pin_on) |-> !o_periodic_wave_pin)
        else $error("pin active while gated");
    a_pulse_single: assert property (sh[4] && sh[2] && sh[1] && !sh[3] && $stable(sh)
        && $rose(o_periodic_wave_pin) |=> !o_periodic_wave_pin)
        else $error("pulse wider than one cycle");
    a_stopped_quiet: assert property (!sh[1] && !$past(sh[1]) && !$past(wr_ctrl)
        |-> !$rose(o_periodic_irq))
        else $error("irq rose while stopped");
    c_irq: cover property ($rose(o_periodic_irq));
    c_err: cover property (o_pslverr);
    c_square: cover property ($rose(o_periodic_wave_pin) && sh[3]);
endmodule

/* File: testbench.sv */
module testbench;
    import apit_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_trim_load = 0;
    logic [APIT_AW-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0;
    logic [5:0] i_trim_flash = '0;
    wire logic [31:0] o_prdata;
    wire logic o_pready, o_pslverr, o_periodic_irq, o_periodic_wave_pin;
    int errors = 0, comparisons = 0, cycles = 0, n, m;
    logic [31:0] r;
    logic e;
    apit_top dut (.*);
    always #25 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= w;
        i_paddr <= {2'b00, a};
        i_pwdata <= {24'h000000, d};
        @(posedge i_sys_clk);
        i_penable <= 1;
        do @(posedge i_sys_clk); while (o_pready !== 1'b1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] k = 8'hFF);
        apb(a, 1'b0, 8'h00);
        check(r & {24'hFFFFFF, k}, {24'h000000, x});
        check(e, 0);
    endtask
    task automatic span(input logic v, output int k);
        k = 0;
        while (o_periodic_wave_pin === v && k < 20000)
        begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
    endtask
    task automatic measure(output int hi, output int lo);
        #1;
        span(1, hi);
        span(0, hi);
        span(1, hi);
        span(0, lo);
    endtask
    initial
    begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 0;
        rd(APIT_ADDR_CTRL, 8'h00);
        rd(APIT_ADDR_RATE_HI, 8'h00);
        apb(12'h2F6, 1'b0, 8'h00);
        check(e, 1);
        @(posedge i_sys_clk);
        i_trim_load <= 1;
        i_trim_flash <= 6'h2A;
        @(posedge i_sys_clk);
        i_trim_load <= 0;
        rd(APIT_ADDR_TRIM, 8'hA8);
        wr(APIT_ADDR_TRIM, 8'hFC);
        rd(APIT_ADDR_TRIM, 8'hFC);
        wr(APIT_ADDR_RATE_HI, 8'h5A);
        rd(APIT_ADDR_RATE_HI, 8'h5A);
        wr(APIT_ADDR_RATE_HI, 8'h00);
        wr(APIT_ADDR_RATE_LO, 8'h03);
        $display("test registers done");
        wr(APIT_ADDR_CTRL, 8'h80);
        rd(APIT_ADDR_CTRL, 8'h80);
        wr(APIT_ADDR_CTRL, 8'h04);
        rd(APIT_ADDR_CTRL, 8'h84, 8'hFE);
        wr(APIT_ADDR_RATE_LO, 8'h09);
        rd(APIT_ADDR_RATE_LO, 8'h03);
        for (int i = 0; i < 2; i++)
        begin
            wr(APIT_ADDR_CTRL, i ? 8'h1C : 8'h0C);
            measure(n, m);
            check(n, i ? 8 : 1);
            check(m, i ? 8 : 7);
        end
        wr(APIT_ADDR_CTRL, 8'h14);
        n = 0;
        repeat (20) begin @(posedge i_sys_clk); #1; n += o_periodic_wave_pin; end
        check(n, 0);
        $display("test wave done");
        wr(APIT_ADDR_CTRL, 8'h07);
        repeat (10) @(posedge i_sys_clk);
        #1;
        check(o_periodic_irq, 1);
        wr(APIT_ADDR_CTRL, 8'h04);
        @(posedge i_sys_clk);
        #1;
        check(o_periodic_irq, 0);
        wr(APIT_ADDR_CTRL, 8'h02);
        repeat (20) @(posedge i_sys_clk);
        rd(APIT_ADDR_CTRL, 8'h83);
        wr(APIT_ADDR_CTRL, 8'h82);
        rd(APIT_ADDR_CTRL, 8'h83);
        wr(APIT_ADDR_CTRL, 8'h03);
        rd(APIT_ADDR_CTRL, 8'h02);
        check(o_periodic_irq, 0);
        $display("test flag done");
        wr(APIT_ADDR_TRIM, 8'h00);
        wr(APIT_ADDR_RATE_LO, 8'h00);
        wr(APIT_ADDR_CTRL, 8'h0C);
        measure(n, m);
        check(n, 2 * APIT_SLOW_CYC);
        check(n + m, 2 * (0 + 1) * 2 * APIT_SLOW_CYC);
        $display("test slow source done");
        wr(APIT_ADDR_TRIM, 8'h80);
        measure(n, m);
        check(n + m, 2 * 2 * (APIT_SLOW_CYC + 32 * APIT_TRIM_STEP));
        wr(APIT_ADDR_TRIM, 8'hC0);
        measure(n, m);
        check(n + m, 2 * 2 * (APIT_SLOW_CYC + 16 * APIT_TRIM_STEP));
        $display("test trim done");
        stop_test();
    end
endmodule
bind apit_top apit_top_asserts u_chk (.*);
